// ===== bench/sync_mem_model.sv
// far-side model: synchronous sram or fifo on the port's memory pins
// assumes the bench routes in the chosen output clock and the latencies
`timescale 1ns/1ps
module sync_mem_model (
    // clock and programmed latencies
    input  wire logic        mem_clk,
    input  wire logic [1:0]  rd_lat,
    input  wire logic [1:0]  wr_lat,
    // memory pins
    input  wire logic [3:0]  space_chip_enable_n,
    input  wire logic        shared_strobe_n,
    input  wire logic        output_enable_n,
    input  wire logic        write_enable_n,
    input  wire logic [19:0] ext_addr,
    input  wire logic [31:0] ext_data_o,
    input  wire logic        ext_data_oe,
    output logic      [31:0] ext_data_i
);
    logic [31:0] mem [logic [19:0]];
    logic [19:0] a_r    = 20'h0;
    logic [1:0]  left_r = 2'h0;
    logic        busy_r = 1'b0;
    logic        wr_r   = 1'b0;
    logic        show_r = 1'b0;
    function automatic logic [31:0] word(input logic [19:0] a);
        return mem.exists(a) ? mem[a] : {12'hC3C, a};
    endfunction
    // zero latency answers straight off the command pins; idle = inverse
    assign ext_data_i = (show_r || (rd_lat == 2'h0 && !output_enable_n &&
        write_enable_n)) ? word(ext_addr) : ~word(a_r);
    always @(posedge mem_clk) begin
        if (!busy_r && !(&space_chip_enable_n) &&
            !(shared_strobe_n && write_enable_n)) begin
            busy_r = 1'b1;
            wr_r   = !write_enable_n;
            a_r    = ext_addr;
            left_r = wr_r ? wr_lat : rd_lat;
        end else if (busy_r) begin
            left_r = left_r - 2'h1;
        end
        if (busy_r && left_r == 2'h0) begin
            if (wr_r && ext_data_oe) mem[a_r] = ext_data_o;
            busy_r = 1'b0;
        end
        // data held 40 ns past the sampling edge for the sync flops
        #40 show_r = busy_r && !wr_r && left_r == 2'h1;
    end
endmodule

// ===== bench/sync_mem_port_tb.sv
// self-checking bench for the programmable synchronous memory port
// assumes default widths: 4 spaces, 20-bit address, 32-bit data
`timescale 1ns/1ps
module sync_mem_port_tb;
    import sync_mem_port_pkg::*;
    logic mclk = 0, rst_n = 0, clk_en = 1, cfg_write = 0, req_valid = 0;
    logic req_write = 0, clk_one = 0, clk_two = 0, clk_sel = 0;
    logic [1:0] cfg_space = 0, req_space = 0, rd_lat = 0, wr_lat = 0;
    logic [CFG_W-1:0] cfg_value = 0, cfg_readback, cfg, cfg_of [4];
    logic [19:0] req_addr = 0, ext_addr;
    logic [31:0] req_wdata = 0, rd_data, ext_data_o, ext_data_i;
    logic [3:0] ce_n;
    logic req_ready, rd_valid, strobe_n, oe_n, we_n, ext_data_oe;
    logic [31:0] q [$];
    int errors = 0, n_compared = 0, desel = 0, oe_alone = 0, d0, o0;
    initial forever #4 mclk = ~mclk;
    initial begin #13; forever #80 clk_one = ~clk_one; end
    initial begin #61; forever #80 clk_two = ~clk_two; end
    sync_mem_port uut (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
        .cfg_write(cfg_write), .cfg_space(cfg_space), .cfg_value(cfg_value),
        .cfg_readback(cfg_readback), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_space(req_space),
        .req_addr(req_addr), .req_wdata(req_wdata), .rd_valid(rd_valid),
        .rd_data(rd_data), .ext_clock_out_one(clk_one),
        .ext_clock_out_two(clk_two), .space_chip_enable_n(ce_n),
        .shared_strobe_n(strobe_n), .output_enable_n(oe_n),
        .write_enable_n(we_n), .ext_addr(ext_addr), .ext_data_o(ext_data_o),
        .ext_data_oe(ext_data_oe), .ext_data_i(ext_data_i));
    sync_mem_model mdl (.mem_clk(clk_sel ? clk_two : clk_one),
        .rd_lat(rd_lat), .wr_lat(wr_lat), .space_chip_enable_n(ce_n),
        .shared_strobe_n(strobe_n), .output_enable_n(oe_n),
        .write_enable_n(we_n), .ext_addr(ext_addr), .ext_data_o(ext_data_o),
        .ext_data_oe(ext_data_oe), .ext_data_i(ext_data_i));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ready lasts one mclk per tick, so look at it mid-cycle
    task automatic wait_ready;
        for (int i = 0; i < 400; i++) begin
            @(negedge mclk);
            if (req_ready === 1'b1) return;
        end
        errors++;
        $display("[ERR] %0t ns: ready never came", $time);
        complete_run();
    endtask
    task automatic access(input logic wr, input logic [19:0] a,
                          input logic [31:0] d);
        @(posedge mclk);
        req_valid <= 1'b1;
        req_write <= wr;
        req_addr  <= a;
        req_wdata <= d;
        wait_ready();
        @(posedge mclk);
        req_valid <= 1'b0;
        if (!wr) q.push_back(d);
    endtask
    always @(posedge mclk) begin
        if (!strobe_n && &ce_n) desel++;
        if (!oe_n && ce_n[req_space]) oe_alone++;
        if (rd_valid === 1'b1) begin
            if (q.size() == 0) check(32'h0, 32'h1);
            else check(rd_data, q.pop_front());
        end
    end
    initial begin
        logic [19:0] a;
        logic [31:0] d;
        void'($urandom(32'hF1EC3721));
        foreach (cfg_of[i]) cfg_of[i] = CFG_RESET;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        @(negedge mclk);
        check({25'h0, cfg_readback}, {25'h0, CFG_RESET});
        check({28'h0, ce_n}, 32'hF);
        for (int c = 0; c < 32; c++) begin
            cfg = {c[4:2], 2'($urandom), c[1:0]};
            a = 20'($urandom);
            d = $urandom;
            @(posedge mclk);
            cfg_write <= 1'b1;
            cfg_space <= 2'($urandom);
            req_space <= 2'h0;
            cfg_value <= cfg;
            @(posedge mclk);
            cfg_write <= 1'b0;
            req_space <= cfg_space;
            cfg_of[cfg_space] = cfg;
            @(negedge mclk);
            check({25'h0, cfg_readback}, {25'h0, cfg});
            rd_lat  = cfg[1:0];
            wr_lat  = cfg[3:2];
            clk_sel = cfg[6];
            access(1'b1, a, d);
            access(1'b0, a, d);
            d0 = desel;
            o0 = oe_alone;
            wait_ready();
            // every read must have been answered before the next ready
            check(32'(q.size()), 32'h0);
            check({31'h0, desel > d0}, {31'h0, !cfg[5]});
            check({31'h0, oe_alone > o0},
                  {31'h0, !cfg[4] && cfg[1:0] != 2'h0});
            $display("test %0d done", c);
        end
        // clock enable low: a config write and every tick are ignored
        @(posedge mclk);
        clk_en    <= 1'b0;
        cfg_write <= 1'b1;
        cfg_space <= 2'h0;
        cfg_value <= ~cfg_of[0];
        repeat (30) begin
            @(negedge mclk);
            check({31'h0, req_ready}, 32'h0);
        end
        @(posedge mclk);
        cfg_write <= 1'b0;
        clk_en    <= 1'b1;
        $display("freeze test done");
        // each space keeps its own word after the others were written
        for (int s = 0; s < 4; s++) begin
            @(posedge mclk);
            cfg_space <= 2'(s);
            @(negedge mclk);
            check({25'h0, cfg_readback}, {25'h0, cfg_of[s]});
        end
        complete_run();
    end
endmodule

// ===== common/sync_mem_port_pkg.sv
// constants for the programmable synchronous memory port
// imported by the port and the bench; widths of data and address are module parameters
package sync_mem_port_pkg;
    // layout of one space's secondary control word
    localparam int CFG_W       = 7;
    localparam int LAT_W       = 2;
    localparam int RL_LSB      = 0;
    localparam int WL_LSB      = 2;
    localparam int CHIP_SELECT_EXTEND_BIT   = 4;
    localparam int ROLE_BIT    = 5;
    localparam int CLKSEL_BIT  = 6;
    localparam logic [CFG_W-1:0] CFG_RESET = 7'h00;
    // tick counter seen only by checks
    localparam int TS_W        = 3;
    localparam logic [TS_W-1:0] TS_MAX = 3'h7;

    typedef enum logic [1:0] {S_IDLE, S_BUSY, S_DESEL} port_state_t;
endpackage

// ===== core/sync_mem_port.sv
// programmable synchronous memory port: one access at a time towards
// pipelined sram, zero-turnaround sram or a synchronous fifo
// assumes both output clocks come from outside and are sampled on mclk
`timescale 1ns/1ps

// What this block does
// R1 - read data sampled 0 to 3 interface cycles after the read command
// R2 - write data driven 0 to 3 interface cycles after the write command
// R3 - extend off: chip enable drops once the command is issued
// R4 - extend on: chip enable held while output enable is low
// R5 - strobe role 0: strobe is address strobe, deselect cycle inserted
// R6 - strobe role 1: strobe is fifo read enable, no deselect cycles
// R7 - all interface pins move on the edge of the chosen output clock
// R8 - three shared pins serve as strobe, output enable and write enable
// R9 - latency, extend, role and clock choice kept per chip-enable space
// R10 - bench memory model (sync_mem_model), not this block, presents read data at the programmed latency
module sync_mem_port
    import sync_mem_port_pkg::*;
#(
    parameter int NUM_SPACES = 4,
    parameter int ADDR_W     = 20,
    parameter int DATA_W     = 32
) (
    // clock, reset, enable
    input  wire logic                       mclk,
    input  wire logic                       rst_n,
    input  wire logic                       clk_en,
    // per-space secondary control
    input  wire logic                       cfg_write,
    input  wire logic [$clog2(NUM_SPACES)-1:0] cfg_space,
    input  wire logic [CFG_W-1:0]           cfg_value,
    output logic      [CFG_W-1:0]           cfg_readback,
    // access request
    input  wire logic                       req_valid,
    output logic                            req_ready,
    input  wire logic                       req_write,
    input  wire logic [$clog2(NUM_SPACES)-1:0] req_space,
    input  wire logic [ADDR_W-1:0]          req_addr,
    input  wire logic [DATA_W-1:0]          req_wdata,
    // read answer
    output logic                            rd_valid,
    output logic      [DATA_W-1:0]          rd_data,
    // output clocks from the clock generator
    input  wire logic                       ext_clock_out_one,
    input  wire logic                       ext_clock_out_two,
    // memory pins
    output logic      [NUM_SPACES-1:0]      space_chip_enable_n,
    output logic                            shared_strobe_n,
    output logic                            output_enable_n,
    output logic                            write_enable_n,
    output logic      [ADDR_W-1:0]          ext_addr,
    output logic      [DATA_W-1:0]          ext_data_o,
    output logic                            ext_data_oe,
    input  wire logic [DATA_W-1:0]          ext_data_i
);
    localparam int SPACE_W = $clog2(NUM_SPACES);

    typedef struct packed {
        logic [1:0]                       clk_s1;
        logic [1:0]                       clk_s2;
        logic [1:0]                       clk_prev;
        logic [DATA_W-1:0]                din_s1;
        logic [DATA_W-1:0]                din_s2;
        logic [NUM_SPACES-1:0][CFG_W-1:0] cfg;
        port_state_t                      st;
        logic [LAT_W-1:0]                 cnt;
        logic [CFG_W-1:0]                 acfg;
        logic                             wr;
        logic [NUM_SPACES-1:0]            ce_n;
        logic                             strobe_n;
        logic                             oe_n;
        logic                             we_n;
        logic [ADDR_W-1:0]                addr;
        logic [DATA_W-1:0]                dout;
        logic                             doe;
        logic [DATA_W-1:0]                rdata;
        logic                             rvalid;
        logic [TS_W-1:0]                  tsince;
    } port_regs_t;

    port_regs_t       state_r;
    port_regs_t       state_nxt;
    logic [1:0]       edges;
    logic             tick;
    logic             accept;
    logic [CFG_W-1:0] req_cfg;

    function automatic logic [LAT_W-1:0] lat_of(input logic [CFG_W-1:0] c,
                                                 input logic is_wr);
        lat_of = is_wr ? c[WL_LSB +: LAT_W] : c[RL_LSB +: LAT_W];
    endfunction

    function automatic logic edge_of(input logic [CFG_W-1:0] c,
                                     input logic [1:0] e);
        edge_of = e[c[CLKSEL_BIT]];
    endfunction

    assign edges     = state_r.clk_s2 & ~state_r.clk_prev;
    assign req_cfg   = state_r.cfg[req_space];
    assign tick      = edge_of(state_r.acfg, edges);    // R7
    // new access starts only on an edge of its own space's clock
    assign req_ready = clk_en && state_r.st == S_IDLE
                       && edge_of(req_cfg, edges);       // R7
    assign accept    = req_valid && req_ready;

    always_comb begin
        state_nxt        = state_r;
        state_nxt.rvalid = 1'b0;
        // two-stage capture of clocks and read data
        state_nxt.clk_s1   = {ext_clock_out_two, ext_clock_out_one};
        state_nxt.clk_s2   = state_r.clk_s1;
        state_nxt.clk_prev = state_r.clk_s2;
        state_nxt.din_s1   = ext_data_i;
        state_nxt.din_s2   = state_r.din_s1;
        if (cfg_write) begin
            state_nxt.cfg[cfg_space] = cfg_value;             // R9
        end
        if (tick && state_r.tsince != TS_MAX) begin
            state_nxt.tsince = state_r.tsince + 3'h1;
        end
        unique case (state_r.st)
            S_IDLE: begin
                if (accept) begin
                    state_nxt.st     = S_BUSY;
                    state_nxt.acfg   = req_cfg;                 // R9
                    state_nxt.wr     = req_write;
                    state_nxt.addr   = req_addr;
                    state_nxt.dout   = req_wdata;
                    state_nxt.cnt    = lat_of(req_cfg, req_write);
                    state_nxt.tsince = '0;
                    state_nxt.ce_n   = ~(NUM_SPACES'(1) << req_space);
                    // fifo mode: read enable only for reads
                    state_nxt.strobe_n = req_write
                                         && req_cfg[ROLE_BIT];  // R8
                    state_nxt.oe_n   = req_write;               // R8
                    state_nxt.we_n   = !req_write;              // R8
                    state_nxt.doe    = req_write
                        && lat_of(req_cfg, 1'b1) == 2'h0;       // R2
                end
            end
            S_BUSY: begin
                if (tick) begin
                    state_nxt.strobe_n = 1'b1;
                    state_nxt.we_n     = 1'b1;
                    // writes never hold output enable, so no extension
                    if (!state_r.acfg[CHIP_SELECT_EXTEND_BIT] || state_r.wr) begin
                        state_nxt.ce_n = '1;                    // R3
                    end
                    if (state_r.cnt == 2'h0) begin
                        state_nxt.oe_n = 1'b1;
                        state_nxt.ce_n = '1;                    // R4
                        state_nxt.doe  = 1'b0;
                        if (!state_r.wr) begin
                            state_nxt.rdata  = state_r.din_s2;  // R1
                            state_nxt.rvalid = 1'b1;
                        end
                        if (state_r.acfg[ROLE_BIT]) begin
                            state_nxt.st = S_IDLE;              // R6
                        end else begin
                            state_nxt.st       = S_DESEL;       // R5
                            state_nxt.strobe_n = 1'b0;
                        end
                    end else begin
                        state_nxt.cnt = state_r.cnt - 2'h1;
                        if (state_r.wr && state_r.cnt == 2'h1) begin
                            state_nxt.doe = 1'b1;               // R2
                        end
                    end
                end
            end
            S_DESEL: begin
                // strobe low with all chip enables high is a deselect
                if (tick) begin
                    state_nxt.strobe_n = 1'b1;
                    state_nxt.st       = S_IDLE;                // R5
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_r          <= '0;
            state_r.cfg      <= {NUM_SPACES{CFG_RESET}};
            state_r.ce_n     <= '1;
            state_r.strobe_n <= 1'b1;
            state_r.oe_n     <= 1'b1;
            state_r.we_n     <= 1'b1;
        end else if (clk_en) begin
            state_r <= state_nxt;
        end
    end

    assign cfg_readback        = state_r.cfg[cfg_space];
    assign rd_valid            = state_r.rvalid;
    assign rd_data             = state_r.rdata;
    assign space_chip_enable_n = state_r.ce_n;
    assign shared_strobe_n     = state_r.strobe_n;
    assign output_enable_n     = state_r.oe_n;
    assign write_enable_n      = state_r.we_n;
    assign ext_addr            = state_r.addr;
    assign ext_data_o          = state_r.dout;
    assign ext_data_oe         = state_r.doe;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence seq_issue_rd;
        accept && !req_write;
    endsequence
    sequence seq_issue_wr;
        accept && req_write;
    endsequence

    AST_READ_LATENCY: assert property ( // R1
        state_r.rvalid |-> state_r.tsince
            == {1'b0, state_r.acfg[RL_LSB +: LAT_W]} + 3'h1)
        else $error("read data taken at wrong latency");
    AST_WRITE_LATENCY: assert property ( // R2
        $rose(state_r.doe) |-> state_r.tsince
            == {1'b0, state_r.acfg[WL_LSB +: LAT_W]})
        else $error("write data driven at wrong latency");
    AST_CE_DROP: assert property ( // R3
        (state_r.st == S_BUSY && !state_r.acfg[CHIP_SELECT_EXTEND_BIT] && $past(tick)
            && $past(state_r.st) == S_BUSY) |-> &space_chip_enable_n)
        else $error("chip enable held after command");
    AST_CE_EXTEND: assert property ( // R4
        (state_r.st == S_BUSY && state_r.acfg[CHIP_SELECT_EXTEND_BIT]
            && !output_enable_n) |-> !(&space_chip_enable_n))
        else $error("chip enable dropped while output enabled");
    AST_DESELECT: assert property ( // R5
        state_r.st == S_DESEL |-> !state_r.acfg[ROLE_BIT]
            && !shared_strobe_n && &space_chip_enable_n)
        else $error("bad deselect cycle");
    AST_NO_DESELECT: assert property ( // R6
        state_r.acfg[ROLE_BIT] |-> state_r.st != S_DESEL)
        else $error("deselect in fifo mode");
    AST_PIN_EDGE: assert property ( // R7
        !$stable(write_enable_n) || !$stable(output_enable_n)
            |-> $past(tick || accept))
        else $error("pin moved off the interface clock");
    AST_READ_CMD: assert property ( // R8
        seq_issue_rd |=> !output_enable_n && write_enable_n
            && !shared_strobe_n)
        else $error("read command strobes wrong");
    AST_WRITE_CMD: assert property ( // R8
        seq_issue_wr |=> !write_enable_n && output_enable_n)
        else $error("write command strobes wrong");
    AST_CFG_STORE: assert property ( // R9
        (cfg_write && clk_en) |=> state_r.cfg[$past(cfg_space)]
            == $past(cfg_value))
        else $error("space control not stored");
endmodule
